// ==== rtl/cda_pkg.sv ====
// shared constants for the complement and decimal adjust alu block
package cda_pkg;

	// ***********************************************************
	// register map, byte addresses on the register bus
	// ***********************************************************
	localparam int        ADDR_W     = 8;
	localparam int        DATA_W     = 32;
	localparam [7:0]      OFS_ACC    = 8'h00;
	localparam [7:0]      OFS_FLAGS  = 8'h04;
	localparam [7:0]      OFS_MADDR  = 8'h08;
	localparam [7:0]      OFS_MDATA  = 8'h0c;
	localparam [7:0]      OFS_CMD    = 8'h10;
	localparam [7:0]      OFS_WDT    = 8'h14;

	// ***********************************************************
	// flag register field positions and reset values
	// ***********************************************************
	localparam int        FLAGS_W    = 5;
	localparam int        FLG_Z      = 0;
	localparam int        FLG_C      = 1;
	localparam int        FLG_AC     = 2;
	localparam int        FLG_TO     = 3;
	localparam int        FLG_PDF    = 4;
	localparam [4:0]      FLAGS_RST  = 5'h00;
	localparam [7:0]      ACC_RST    = 8'h00;
	localparam [7:0]      MEM_RST    = 8'h00;

	// ***********************************************************
	// command codes written to the command register
	// ***********************************************************
	localparam int        CMD_W          = 3;
	localparam [2:0]      CMD_INV_MEM    = 3'h1;
	localparam [2:0]      CMD_INV_ACC    = 3'h2;
	localparam [2:0]      CMD_DEC_ADJ    = 3'h3;
	localparam [2:0]      CMD_WD_CLR     = 3'h4;
	localparam [2:0]      CMD_ADD        = 3'h5;
	localparam [2:0]      CMD_HALT       = 3'h6;

	// ***********************************************************
	// decimal adjust constants
	// ***********************************************************
	localparam [3:0]      BCD_MAX    = 4'h9;
	localparam [3:0]      BCD_FIX    = 4'h6;
	localparam [3:0]      NIB_ZERO   = 4'h0;

endpackage

// ==== rtl/cda_alu.sv ====
// complement and decimal adjust alu slice with apb register access
`timescale 1ns/100ps
// Function
// - invert memory op writes inverted byte back, zero flag from result
// - invert to accumulator op loads inverted byte, memory kept, zero flag
// - decimal adjust adds six to low nibble if above nine or half carry
// - decimal adjust adds six to high nibble if above nine or carry
// - adjust result is accumulator plus 00, 06, 60 or 66, into memory
// - decimal adjust touches only carry, which flags decimal overflow
// - watchdog clear resets counter and powerdown flag, and timeout unless the counter is all ones
module cda_alu #(
	parameter int MEM_DEPTH = 16,
	parameter int WDT_W     = 16
) (
	input  wire logic                       CLK,
	input  wire logic                       RST,
	input  wire logic                       CLK_EN,
	input  wire logic                       PSEL,
	input  wire logic                       PENABLE,
	input  wire logic                       PWRITE,
	input  wire logic [cda_pkg::ADDR_W-1:0] PADDR,
	input  wire logic [cda_pkg::DATA_W-1:0] PWDATA,
	output logic      [cda_pkg::DATA_W-1:0] PRDATA,
	output logic                            PREADY,
	output logic                            PSLVERR
);
	import cda_pkg::*;

	localparam int MA_W = $clog2(MEM_DEPTH);

	logic [7:0]         mem_q [MEM_DEPTH];
	logic [7:0]         acc_reg;
	logic [7:0]         acc_next;
	logic [FLAGS_W-1:0] flags_reg;
	logic [FLAGS_W-1:0] flags_next;
	logic [MA_W-1:0]    maddr_reg;
	logic [WDT_W-1:0]   wdt_reg;
	logic [DATA_W-1:0]  prdata_reg;
	logic               cap_reg;

	// ***********************************************************
	// bus decode
	// ***********************************************************
	// ready only after a captured setup, so read data is never stale
	wire pready_w  = CLK_EN & cap_reg;
	wire acc_phase = PSEL & PENABLE;
	wire wr_fire   = acc_phase & PWRITE & pready_w;
	wire hit_acc   = (PADDR == OFS_ACC);
	wire hit_flags = (PADDR == OFS_FLAGS);
	wire hit_maddr = (PADDR == OFS_MADDR);
	wire hit_mdata = (PADDR == OFS_MDATA);
	wire hit_cmd   = (PADDR == OFS_CMD);
	wire hit_wdt   = (PADDR == OFS_WDT);
	wire hit_any   = hit_acc | hit_flags | hit_maddr | hit_mdata
		| hit_cmd | hit_wdt;

	// command strobes, one per accepted write to the command register
	wire             cmd_fire   = wr_fire & hit_cmd;
	wire [CMD_W-1:0] cmd        = PWDATA[CMD_W-1:0];
	wire             exec_cpl   = cmd_fire & (cmd == CMD_INV_MEM);
	wire             exec_invert_to_accumulator_op  = cmd_fire & (cmd == CMD_INV_ACC);
	wire             exec_daa   = cmd_fire & (cmd == CMD_DEC_ADJ);
	wire             exec_clr   = cmd_fire & (cmd == CMD_WD_CLR);
	wire             exec_add   = cmd_fire & (cmd == CMD_ADD);
	wire             exec_halt  = cmd_fire & (cmd == CMD_HALT);

	// ***********************************************************
	// datapath
	// ***********************************************************
	wire [7:0] mem_rd  = mem_q[maddr_reg];
	wire [7:0] cpl_res = ~mem_rd;
	wire       c_flag  = flags_reg[FLG_C];
	wire       ac_flag = flags_reg[FLG_AC];
	wire       lo_fix  = (acc_reg[3:0] > BCD_MAX) | ac_flag;
	wire       hi_fix  = (acc_reg[7:4] > BCD_MAX) | c_flag;
	wire [7:0] daa_corr = {hi_fix ? BCD_FIX : NIB_ZERO,
		lo_fix ? BCD_FIX : NIB_ZERO};
	wire [8:0] daa_sum  = {1'b0, acc_reg} + {1'b0, daa_corr};
	wire [8:0] add_sum  = {1'b0, acc_reg} + {1'b0, mem_rd};
	wire [4:0] add_half = {1'b0, acc_reg[3:0]} + {1'b0, mem_rd[3:0]};
	wire       wdt_ovf  = &wdt_reg;

	// memory write port: bus data, complement or adjust result
	wire       mem_we = exec_cpl | exec_daa | (wr_fire & hit_mdata);
	wire [7:0] mem_wd = exec_cpl ? cpl_res
		: exec_daa ? daa_sum[7:0] : PWDATA[7:0];

	// ***********************************************************
	// accumulator and flag next state
	// ***********************************************************
	// later assignments win; the timeout set stays last so it beats clears
	always_comb begin
		acc_next   = acc_reg;
		flags_next = flags_reg;
		if (wr_fire & hit_acc) begin
			acc_next = PWDATA[7:0];
		end
		if (wr_fire & hit_flags) begin
			flags_next = PWDATA[FLAGS_W-1:0];
		end
		if (exec_cpl) begin
			flags_next[FLG_Z] = (cpl_res == 8'h00);
		end
		if (exec_invert_to_accumulator_op) begin
			acc_next          = cpl_res;
			flags_next[FLG_Z] = (cpl_res == 8'h00);
		end
		if (exec_daa) begin
			flags_next[FLG_C] = hi_fix | daa_sum[8];
		end
		if (exec_add) begin
			acc_next           = add_sum[7:0];
			flags_next[FLG_C]  = add_sum[8];
			flags_next[FLG_AC] = add_half[4];
			flags_next[FLG_Z]  = (add_sum[7:0] == 8'h00);
		end
		if (exec_clr) begin
			flags_next[FLG_TO]  = 1'b0;
			flags_next[FLG_PDF] = 1'b0;
		end
		if (exec_halt) begin
			flags_next[FLG_PDF] = 1'b1;
		end
		if (wdt_ovf) begin
			flags_next[FLG_TO] = 1'b1;
		end
	end

	// ***********************************************************
	// state registers
	// ***********************************************************
	// core registers, frozen while the clock enable is low
	always_ff @(posedge CLK) begin
		if (RST) begin
			acc_reg   <= ACC_RST;
			flags_reg <= FLAGS_RST;
			maddr_reg <= '0;
		end else if (CLK_EN) begin
			acc_reg   <= acc_next;
			flags_reg <= flags_next;
			if (wr_fire & hit_maddr) begin
				maddr_reg <= PWDATA[MA_W-1:0];
			end
		end
	end

	// watchdog counter free runs and wraps
	always_ff @(posedge CLK) begin
		if (RST) begin
			wdt_reg <= '0;
		end else if (CLK_EN) begin
			if (exec_clr) begin
				wdt_reg <= '0;
			end else begin
				wdt_reg <= wdt_reg + 1'b1;
			end
		end
	end

	// data memory, one flip-flop byte per entry
	for (genvar i = 0; i < MEM_DEPTH; i++) begin : g_mem
		always_ff @(posedge CLK) begin
			if (RST) begin
				mem_q[i] <= MEM_RST;
			end else if (CLK_EN & mem_we & (maddr_reg == MA_W'(i))) begin
				mem_q[i] <= mem_wd;
			end
		end
	end

	// ***********************************************************
	// bus answer
	// ***********************************************************
	wire [DATA_W-1:0] rd_val = hit_acc ? DATA_W'(acc_reg)
		: hit_flags ? DATA_W'(flags_reg)
		: hit_maddr ? DATA_W'(maddr_reg)
		: hit_mdata ? DATA_W'(mem_rd)
		: hit_wdt ? DATA_W'(wdt_reg) : '0;

	// read data captured each enabled edge of a transfer
	always_ff @(posedge CLK) begin
		if (RST) begin
			prdata_reg <= '0;
			cap_reg    <= 1'b0;
		end else if (CLK_EN) begin
			cap_reg <= PSEL & ~(acc_phase & pready_w);
			if (PSEL) begin
				prdata_reg <= rd_val;
			end
		end
	end

	assign PRDATA  = prdata_reg;
	assign PREADY  = pready_w;
	assign PSLVERR = acc_phase & pready_w & ~hit_any;

	// ***********************************************************
	// assertions
	// ***********************************************************
	default clocking cb @(posedge CLK); endclocking
	default disable iff (RST);

	sequence s_daa_issue;
		exec_daa;
	endsequence

	sequence s_add_issue;
		exec_add;
	endsequence

	a_cpl_mem_inv: assert property (
		exec_cpl |=> mem_q[$past(maddr_reg)] == ~$past(mem_rd)
			&& flags_reg[FLG_Z] == ($past(mem_rd) == 8'hff))
		else $error("invert memory op result or zero flag wrong");

	a_invert_to_accumulator_op_acc_inv: assert property (
		exec_invert_to_accumulator_op |=> acc_reg == ~$past(mem_rd)
			&& mem_rd == $past(mem_rd)
			&& flags_reg[FLG_Z] == ($past(mem_rd) == 8'hff))
		else $error("invert to accumulator op wrong");

	// low nibble kept when no fix is due
	a_daa_low_keep: assert property (
		s_daa_issue ##0 (acc_reg[3:0] < 4'ha) && !ac_flag
			|=> mem_q[$past(maddr_reg)][3:0] == $past(acc_reg[3:0]))
		else $error("decimal adjust changed low nibble");

	// high nibble above nine sets carry
	a_daa_high_fix: assert property (
		s_daa_issue ##0 (acc_reg[7:4] > 4'h9 || c_flag)
			|=> flags_reg[FLG_C])
		else $error("decimal adjust missed high nibble fix");

	a_daa_result: assert property (
		s_daa_issue |=> mem_q[$past(maddr_reg)] == 8'($past(acc_reg)
			+ ($past(hi_fix) ? 8'h60 : 8'h00)
			+ ($past(lo_fix) ? 8'h06 : 8'h00)))
		else $error("decimal adjust result wrong");

	a_daa_flags: assert property (
		s_daa_issue ##1 1'b1 |-> $stable(flags_reg[FLG_Z])
			&& $stable(flags_reg[FLG_AC])
			&& $stable(acc_reg))
		else $error("decimal adjust changed another flag");

	a_wdt_clear: assert property (
		exec_clr && !exec_halt |=> wdt_reg == '0
			&& !flags_reg[FLG_PDF]
			&& flags_reg[FLG_TO] == $past(wdt_ovf))
		else $error("watchdog clear incomplete");

	a_add_half: assert property (
		s_add_issue |=> flags_reg[FLG_AC]
			== (({1'b0, $past(acc_reg[3:0])}
			+ {1'b0, $past(mem_rd[3:0])}) > 5'h0f))
		else $error("half carry not from bit three");

endmodule

// ==== tb/cda_alu_tb.sv ====
// self-checking bench for the complement and decimal adjust alu
`timescale 1ns/100ps
module cda_alu_tb;
	import cda_pkg::*;
	logic        clk, rst, clk_en, psel, penable, pwrite, pready, pslverr;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata;
	logic [15:0] seed, en_seed;
	int          fails, comparisons, cycles;

	cda_alu #(.MEM_DEPTH(16), .WDT_W(16)) dut (.CLK(clk), .RST(rst),
		.CLK_EN(clk_en), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
		.PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
		.PSLVERR(pslverr));

	// ***********************************************************
	// helper functions
	// ***********************************************************
	// maximal length 16-bit sequence
	function automatic logic [15:0] lfsr(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction
	// expected adjust, carry on top; fixes judged on the original byte
	function automatic logic [8:0] daa(input logic [7:0] a, input logic c,
			input logic h);
		logic       lo, hi;
		logic [8:0] s;
		lo = (a[3:0] > BCD_MAX) || h;
		hi = (a[7:4] > BCD_MAX) || c;
		s = {1'b0, a} + {1'b0, hi ? BCD_FIX : NIB_ZERO, lo ? BCD_FIX : NIB_ZERO};
		return {hi | s[8], s[7:0]};
	endfunction

	// ***********************************************************
	// clock, stalls and timeout
	// ***********************************************************
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	// enable drops about one cycle in four so bus waits get stretched
	always @(posedge clk) begin
		en_seed <= lfsr(en_seed);
		clk_en  <= rst | (en_seed[1:0] != 2'b00);
		cycles  <= cycles + 1;
		if (cycles == 20000) begin
			fails = fails + 1;
			print_verdict();
		end
	end

	// ***********************************************************
	// bus tasks and comparisons
	// ***********************************************************
	task automatic print_verdict();
		if (fails == 0 && comparisons > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			fails++;
			$display("unexpected at %0t: got %h want %h", $time, got, exp);
		end
	endtask
	// one transfer; answer taken at the rising edge that sees pready high
	task automatic apb(input logic wr, input logic [7:0] a,
			input logic [31:0] d, output logic [31:0] q, output logic e);
		@(posedge clk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= wr;
		paddr   <= a;
		pwdata  <= d;
		@(posedge clk);
		penable <= 1'b1;
		do
			@(posedge clk);
		while (pready !== 1'b1);
		q = prdata;
		e = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		logic        e;
		apb(1'b1, a, d, q, e);
		check({31'h0, e}, 32'h0);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] exp);
		logic [31:0] q;
		logic        e;
		apb(1'b0, a, 32'h0, q, e);
		check({31'h0, e}, 32'h0);
		check(q, exp);
	endtask

	// ***********************************************************
	// main sequence
	// ***********************************************************
	initial begin
		logic [7:0]  a, b;
		logic [8:0]  s, d;
		logic [4:0]  f;
		logic [31:0] q;
		logic        e, h;
		{rst, clk_en, psel, penable, pwrite} = 5'h19;
		paddr = 8'h00;
		pwdata = 32'h0;
		{seed, en_seed} = {16'h004d, 16'h004d};
		{fails, comparisons, cycles} = {32'h0, 32'h0, 32'h0};
		repeat (10) @(posedge clk);
		rst <= 1'b0;
		rd(OFS_ACC, 32'h0);
		rd(OFS_FLAGS, 32'h0);
		// unmapped place is refused, reads zero, changes nothing
		apb(1'b1, 8'h18, 32'hff, q, e);
		check({31'h0, e}, 32'h1);
		apb(1'b0, 8'h18, 32'h0, q, e);
		check({q[30:0], e}, 32'h1);
		for (int i = 0; i < 40; i++) begin
			seed = lfsr(seed);
			a = (i == 0) ? 8'hff : (i == 2) ? 8'h09 : seed[7:0];
			b = (i == 1) ? 8'h99 : (i == 2) ? 8'h08 : seed[15:8];
			wr(OFS_MADDR, {28'h0, seed[11:8]});
			wr(OFS_MDATA, {24'h0, a});
			wr(OFS_FLAGS, 32'h0);
			wr(OFS_CMD, {29'h0, CMD_INV_MEM});
			rd(OFS_MDATA, {24'h0, ~a});
			rd(OFS_FLAGS, {31'h0, a == 8'hff});
			wr(OFS_ACC, {24'h0, b});
			wr(OFS_CMD, {29'h0, CMD_INV_ACC});
			rd(OFS_ACC, {24'h0, a});
			rd(OFS_MDATA, {24'h0, ~a});
			rd(OFS_FLAGS, {31'h0, a == 8'h00});
			// on even passes the add sets up the carries that the adjust consumes
			wr(OFS_MDATA, {24'h0, b});
			wr(OFS_CMD, {29'h0, CMD_ADD});
			s = {1'b0, a} + {1'b0, b};
			h = ({1'b0, a[3:0]} + {1'b0, b[3:0]}) > 5'h0f;
			f = {2'b00, h, s[8], s[7:0] == 8'h00};
			rd(OFS_ACC, {24'h0, s[7:0]});
			rd(OFS_FLAGS, {27'h0, f});
			if (i[0]) begin
				f[2:1] = seed[13:12];
				wr(OFS_FLAGS, {27'h0, f});
			end
			wr(OFS_CMD, {29'h0, CMD_DEC_ADJ});
			d = daa(s[7:0], f[FLG_C], f[FLG_AC]);
			rd(OFS_MDATA, {24'h0, d[7:0]});
			f[FLG_C] = d[8];
			rd(OFS_FLAGS, {27'h0, f});
			rd(OFS_ACC, {24'h0, s[7:0]});
		end
		// unknown command code and command readback leave all alone
		wr(OFS_CMD, 32'h7);
		rd(OFS_CMD, 32'h0);
		rd(OFS_ACC, {24'h0, s[7:0]});
		// halt and a written timeout, then the watchdog clear drops both
		wr(OFS_FLAGS, 32'h8);
		wr(OFS_CMD, {29'h0, CMD_HALT});
		rd(OFS_FLAGS, 32'h18);
		wr(OFS_CMD, {29'h0, CMD_WD_CLR});
		rd(OFS_FLAGS, 32'h0);
		apb(1'b0, OFS_WDT, 32'h0, q, e);
		check({31'h0, q < 32'h10}, 32'h1);
		print_verdict();
	end
endmodule
